// *** flash_engine_pkg.sv ***
// constants and types of the serial flash command engine
package flash_engine_pkg;

  // array geometry
  localparam int ADDR_W = 17;
  localparam int MEM_BYTES = 131072;
  localparam int PAGE_BYTES = 256;
  localparam logic [11:0] UNIT_MASK = 12'hFFF;
  localparam logic [15:0] LARGE_MASK = 16'hFFFF;
  localparam logic [16:0] FULL_MASK = 17'h1FFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // opcode values, configurable
  localparam logic [7:0] OP_READ = 8'h31;
  localparam logic [7:0] OP_FAST_READ = 8'h32;
  localparam logic [7:0] OP_DUAL_READ = 8'h33;
  localparam logic [7:0] OP_STATUS_READ = 8'h34;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h35;
  localparam logic [7:0] OP_UNIT_WIPE = 8'h36;
  localparam logic [7:0] OP_LARGE_WIPE = 8'h37;
  localparam logic [7:0] OP_FULL_WIPE = 8'h38;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h39;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'h3A;
  localparam logic [7:0] OP_WAKE = 8'h3B;

  // bit counts inside a frame
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_END = 6'h20;
  localparam logic [5:0] DUMMY_END = 6'h28;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [2:0] SINGLE_LAST = 3'h7;
  localparam logic [2:0] DUAL_LAST = 3'h3;

  // status word layout
  localparam int STAT_BUSY = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_BP_LO = 2;
  localparam int STAT_BP_HI = 3;
  localparam int STAT_LOCK = 7;
  localparam int STAT_SLEEP = 8;

  // reset values
  localparam logic [8:0] STAT_RESET = 9'h000;
  localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

  // self-timed cycle durations
  localparam int CLK_FREQ_MHZ = 100;
  localparam int PAGE_WRITE_TIME_US = 3000;
  localparam int UNIT_WIPE_TIME_US = 40000;
  localparam int LARGE_WIPE_TIME_US = 1000000;
  localparam int FULL_WIPE_TIME_US = 2000000;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_WORK = 2'b01,
    ENG_WAIT = 2'b10
  } eng_state_t;

endpackage : flash_engine_pkg

// *** serial_flash_read_write_engine.sv ***
// serial flash command engine: link shifter, self-timed cycles, array
//
// Behaviour
// R1: hardware lock mode ends only once the write-protect pin is high; here it also ends when status_lock_bit_i goes low.
// R2: address sampled on rising serial clock, data shifted out on falling edges.
// R3: read address advances after each byte and wraps to zero at the top.
// R4: normal read is opcode, 3-byte address, then data until chip select rises.
// R5: fast read has one dummy byte after the address before data.
// R6: fast read is ignored while a self-timed cycle runs.
// R7: dual read puts two bits per falling edge on both data pins.
// R8: dual read is ignored while a self-timed cycle runs.
// R9: only dual read array data uses two pins; all else stays single-bit.
// R10: erase and page write need the write enable latch set beforehand.
// R11: unit wipe selects its sector by A12 upward and sets it to ones.
// R12: erase commands are discarded unless chip select rises on the exact bit count.
// R13: accepted cycle starts at chip select rise, busy held, then busy and latch clear.
// R14: no unit wipe, large wipe or page write inside the protected region.
// R15: large wipe sets its whole 64K block to ones.
// R16: full wipe runs only when both protect level bits are zero.
// R17: host sends full wipe as the opcode alone.
// R18: more than 256 data bytes keep only the last 256.
// R19: page data past the page end wraps to the page start.
// R20: host sends page write as opcode, address, at least one data byte.
// R21: page write changes only the addressed bytes of the page.
// R22: only deep sleep enters sleep; sleep ignores write, program and erase.
// R23: host sends deep sleep as the opcode alone.
// R24: write unlock sets the write enable latch, the only path to writes.
// R25: status: bit0 busy, bit1 latch, bits 3:2 protect level, bit7 lock.
// R26: in sleep only the wake command is decoded.
// R27: opcode values are configurable constants.
// R28: cycle durations are parameters of the busy counter.
`timescale 1ns/1ps
module serial_flash_read_write_engine
  import flash_engine_pkg::*;
#(
  parameter int unsigned PAGE_WRITE_CYCLES = PAGE_WRITE_TIME_US * CLK_FREQ_MHZ,
  parameter int unsigned UNIT_WIPE_CYCLES = UNIT_WIPE_TIME_US * CLK_FREQ_MHZ,
  parameter int unsigned LARGE_WIPE_CYCLES = LARGE_WIPE_TIME_US * CLK_FREQ_MHZ,
  parameter int unsigned FULL_WIPE_CYCLES = FULL_WIPE_TIME_US * CLK_FREQ_MHZ
) (
  // system clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sio0_i,
  output logic sio0_o,
  output logic sio0_oe_o,
  output logic so_o,
  output logic so_oe_o,
  input wire logic write_protect_n_i,
  // configuration
  input wire logic protect_level_high_i,
  input wire logic protect_level_low_i,
  input wire logic status_lock_bit_i,
  // status
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic deep_sleep_o,
  output logic hardware_lock_mode_o
);

  // array, written only on the system clock
  logic [7:0] mem [MEM_BYTES];
  // page buffer, written only on the link clock
  logic [7:0] pbuf [PAGE_BYTES];

  function automatic logic is_protected(input logic [1:0] bp, input logic [16:0] a);
    logic res;
    res = 1'b0;
    if (bp == 2'b01) begin
      res = a[16];
    end else if (bp != 2'b00) begin
      res = 1'b1;
    end
    return res;
  endfunction : is_protected

  // ---------------- link clock domain ----------------
  logic in_frame_r;
  logic [5:0] cnt_r;
  logic [7:0] opcode_r;
  logic [23:0] addr_r;
  logic [2:0] sub_r;
  logic [16:0] rd_addr_r;
  logic [7:0] pdat_r;
  logic [7:0] pidx_r;
  logic [255:0] pvalid_r;
  logic got_byte_r;
  logic [8:0] stat_s1_r;
  logic [8:0] stat_s2_r;
  // status word of the system side, synchronised below
  logic [8:0] stat_r;

  wire first_bit = !in_frame_r;
  wire op_read = (opcode_r == OP_READ); // see R27
  wire op_fast = (opcode_r == OP_FAST_READ);
  wire op_dual = (opcode_r == OP_DUAL_READ);
  wire op_stat = (opcode_r == OP_STATUS_READ);
  wire op_pw = (opcode_r == OP_PAGE_WRITE);
  wire busy_s = stat_s2_r[STAT_BUSY];
  wire sleep_s = stat_s2_r[STAT_SLEEP];
  wire [5:0] data_start = (op_fast || op_dual) ? DUMMY_END : (op_stat ? OPCODE_BITS : ADDR_END); // see R5
  wire in_data = in_frame_r && (cnt_r >= data_start);
  wire read_ok = (op_read || op_fast || op_dual) && !busy_s && !sleep_s; // see R6 see R8 see R26
  wire stat_ok = op_stat && !sleep_s; // see R26
  wire [2:0] sub_last = op_dual ? DUAL_LAST : SINGLE_LAST;
  wire byte_done = in_data && (sub_r == sub_last);
  wire pw_ok = op_pw && !busy_s && !sleep_s;
  wire [5:0] cnt_nxt = first_bit ? 6'h01 : ((cnt_r == CNT_MAX) ? cnt_r : cnt_r + 6'h01);
  wire [7:0] mem_q = mem[rd_addr_r];
  wire [7:0] cur_byte = op_stat ? stat_s2_r[7:0] : mem_q;
  wire [2:0] idx_hi = op_dual ? (3'h7 - {sub_r[1:0], 1'b0}) : (3'h7 - sub_r);
  wire [2:0] idx_lo = 3'h6 - {sub_r[1:0], 1'b0};
  wire out_en = in_data && (read_ok || stat_ok);
  wire dual_en = in_data && op_dual && read_ok; // see R7 see R9

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
    end
  end

  // bit count and command capture, kept after the frame for the system side
  always_ff @(posedge sclk_i) begin
    cnt_r <= cnt_nxt;
    if (first_bit) begin
      opcode_r <= {7'h00, sio0_i};
    end else if (cnt_r < OPCODE_BITS) begin
      opcode_r <= {opcode_r[6:0], sio0_i};
    end else if (cnt_r < ADDR_END) begin
      addr_r <= {addr_r[22:0], sio0_i}; // see R2 see R4
    end
  end

  // read address and position in the byte
  always_ff @(posedge sclk_i) begin
    if (first_bit) begin
      sub_r <= 3'h0;
    end else if (in_data) begin
      sub_r <= byte_done ? 3'h0 : sub_r + 3'h1;
    end
    if (!first_bit && cnt_r == ADDR_END - 6'h01) begin
      rd_addr_r <= {addr_r[15:0], sio0_i};
    end else if (byte_done) begin
      rd_addr_r <= rd_addr_r + 17'h00001; // see R3
    end
  end

  // page data capture: index wraps in the page, later bytes overwrite
  always_ff @(posedge sclk_i) begin
    if (first_bit) begin
      got_byte_r <= 1'b0;
    end else begin
      if (cnt_r == ADDR_END - 6'h01) begin
        pidx_r <= {addr_r[6:0], sio0_i};
      end
      // cleared only for an accepted frame, a running cycle still reads it
      if (cnt_r == ADDR_END - 6'h01 && pw_ok) begin
        pvalid_r <= '0;
      end
      if (in_data && op_pw) begin
        pdat_r <= {pdat_r[6:0], sio0_i};
      end
      if (byte_done && pw_ok) begin
        pbuf[pidx_r] <= {pdat_r[6:0], sio0_i}; // see R18
        pvalid_r[pidx_r] <= 1'b1;
        pidx_r <= pidx_r + 8'h01; // see R19
        got_byte_r <= 1'b1;
      end
    end
  end

  // status and sleep levels into the link domain
  always_ff @(posedge sclk_i) begin
    stat_s1_r <= stat_r;
    stat_s2_r <= stat_s1_r;
  end

  // data out on the falling edge
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_o <= 1'b0;
      sio0_o <= 1'b0;
      so_oe_o <= 1'b0;
      sio0_oe_o <= 1'b0;
    end else begin
      so_o <= cur_byte[idx_hi]; // see R2 see R7
      sio0_o <= cur_byte[idx_lo];
      so_oe_o <= out_en;
      sio0_oe_o <= dual_en;
    end
  end

  // ---------------- system clock domain ----------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic wp_s1_r;
  logic wp_s2_r;
  eng_state_t state_r;
  eng_state_t state_nxt;
  logic busy_r;
  logic wel_r;
  logic sleep_r;
  logic hw_lock_r;
  logic wipe_r;
  logic [16:0] work_r;
  logic [16:0] work_last_r;
  logic [31:0] timer_r;

  wire frame_end = cs_s2_r && !cs_s3_r;
  wire [1:0] bp = {protect_level_high_i, protect_level_low_i};
  wire [16:0] cmd_addr = addr_r[16:0];
  wire idle = (state_r == ENG_IDLE);
  wire len8 = (cnt_r == OPCODE_BITS);
  wire len32 = (cnt_r == ADDR_END);
  wire can_write = frame_end && idle && wel_r && !sleep_r; // see R10 see R22 see R24
  wire prot = is_protected(bp, cmd_addr); // see R14
  wire go_unit = can_write && (opcode_r == OP_UNIT_WIPE) && len32 && !prot; // see R11 see R12
  wire go_large = can_write && (opcode_r == OP_LARGE_WIPE) && len32 && !prot; // see R12 see R15
  wire go_full = can_write && (opcode_r == OP_FULL_WIPE) && len8 && (bp == 2'b00); // see R16
  wire go_page = can_write && op_pw && got_byte_r && !prot;
  wire go_any = go_unit || go_large || go_full || go_page;
  wire set_wel = frame_end && idle && !sleep_r && (opcode_r == OP_WRITE_UNLOCK) && len8;
  wire set_sleep = frame_end && idle && (opcode_r == OP_DEEP_SLEEP) && len8; // see R22
  wire clr_sleep = frame_end && idle && sleep_r && (opcode_r == OP_WAKE) && len8; // see R26
  wire work_done = (work_r == work_last_r);
  wire cycle_end = (state_r == ENG_WAIT) && (timer_r == TIMER_RESET);
  wire [16:0] base_unit = {cmd_addr[16:12], 12'h000};
  wire [16:0] base_large = {cmd_addr[16], 16'h0000};
  wire [16:0] base_page = {cmd_addr[16:8], 8'h00};
  wire [16:0] start_nxt = go_full ? 17'h00000 : (go_large ? base_large
                        : (go_unit ? base_unit : base_page));
  wire [16:0] last_nxt = go_full ? FULL_MASK : (go_large ? (base_large | {1'b0, LARGE_MASK})
                       : (go_unit ? (base_unit | {5'h00, UNIT_MASK}) : (base_page | 17'h000FF)));
  wire [31:0] time_nxt = go_full ? 32'(FULL_WIPE_CYCLES) : (go_large ? 32'(LARGE_WIPE_CYCLES)
                       : (go_unit ? 32'(UNIT_WIPE_CYCLES) : 32'(PAGE_WRITE_CYCLES))); // see R28
  wire [7:0] prog_byte = mem[work_r] & pbuf[work_r[7:0]];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ENG_IDLE: if (go_any) state_nxt = ENG_WORK; // see R13
      ENG_WORK: if (work_done) state_nxt = ENG_WAIT;
      ENG_WAIT: if (timer_r == TIMER_RESET) state_nxt = ENG_IDLE;
      default: state_nxt = ENG_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      wp_s1_r <= write_protect_n_i;
      wp_s2_r <= wp_s1_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r <= ENG_IDLE;
      timer_r <= TIMER_RESET;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (go_any) begin
        timer_r <= time_nxt;
      end else if (timer_r != TIMER_RESET) begin
        timer_r <= timer_r - 32'h0000_0001;
      end
      busy_r <= go_any || (busy_r && !cycle_end); // see R13
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wel_r <= 1'b0;
      sleep_r <= 1'b0;
      hw_lock_r <= 1'b0;
      stat_r <= STAT_RESET;
    end else begin
      if (set_wel) begin
        wel_r <= 1'b1; // see R24
      end else if (cycle_end) begin
        wel_r <= 1'b0; // see R13
      end
      if (set_sleep) begin
        sleep_r <= 1'b1;
      end else if (clr_sleep) begin
        sleep_r <= 1'b0;
      end
      hw_lock_r <= status_lock_bit_i && !wp_s2_r; // see R1
      stat_r <= {sleep_r, status_lock_bit_i, 3'b000, bp, wel_r, busy_r}; // see R25
    end
  end

  // cycle work: erase to ones or program the captured page
  always_ff @(posedge clock_i) begin
    if (go_any) begin
      work_r <= start_nxt;
      work_last_r <= last_nxt;
      wipe_r <= !go_page;
    end else if (state_r == ENG_WORK && !work_done) begin
      work_r <= work_r + 17'h00001;
    end
    if (state_r == ENG_WORK) begin
      if (wipe_r) begin
        mem[work_r] <= ERASED_BYTE; // see R11 see R15 see R16
      end else if (pvalid_r[work_r[7:0]]) begin
        mem[work_r] <= prog_byte; // see R21
      end
    end
  end

  assign write_in_progress_o = busy_r;
  assign write_enable_latch_o = wel_r;
  assign deep_sleep_o = sleep_r;
  assign hardware_lock_mode_o = hw_lock_r;

  // ---------------- checks ----------------
  busy_hold_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R13
    (state_r != ENG_IDLE) |-> busy_r) else $error("busy low during a cycle");
  latch_clear_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R13
    $fell(busy_r) |-> !wel_r && idle) else $error("latch not cleared at cycle end");
  need_latch_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R10
    (frame_end && idle && !wel_r) |=> idle [*3]) else $error("cycle started without latch");
  protect_block_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R14
    (frame_end && idle && prot && (opcode_r != OP_FULL_WIPE)) |=> !busy_r)
    else $error("protected region altered");
  full_guard_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R16
    (frame_end && idle && (opcode_r == OP_FULL_WIPE) && (bp != 2'b00)) |=> !busy_r)
    else $error("full wipe ran while protected");
  exact_len_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R12
    (frame_end && idle && (opcode_r == OP_UNIT_WIPE) && !len32) |=> !busy_r)
    else $error("unit wipe taken on wrong length");
  sleep_entry_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R22
    (frame_end && idle && (opcode_r == OP_DEEP_SLEEP) && len8) |=> sleep_r ##1 !busy_r)
    else $error("deep sleep not entered");
  sleep_ignore_a: assert property (@(posedge clock_i) disable iff (reset_i) // see R22
    (sleep_r && frame_end) |=> !busy_r && $stable(wel_r)) else $error("write taken in sleep");
  addr_step_a: assert property (@(posedge sclk_i) disable iff (cs_n_i) // see R3
    (in_frame_r && byte_done && (cnt_r != ADDR_END - 6'h01))
    |=> (rd_addr_r == $past(rd_addr_r) + 17'h00001))
    else $error("read address did not advance");
  dual_only_a: assert property (@(negedge sclk_i) disable iff (cs_n_i) // see R9
    sio0_oe_o |-> op_dual && so_oe_o) else $error("second pin driven outside dual read");
  busy_reject_a: assert property (@(negedge sclk_i) disable iff (cs_n_i) // see R6
    (busy_s && (op_fast || op_dual)) |=> !so_oe_o) else $error("read served while busy");

  unit_wipe_c: cover property (@(posedge clock_i) disable iff (reset_i) go_unit);
  page_write_c: cover property (@(posedge clock_i) disable iff (reset_i) go_page ##1 busy_r);
  dual_data_c: cover property (@(negedge sclk_i) disable iff (cs_n_i) sio0_oe_o);
  addr_wrap_c: cover property (@(posedge sclk_i) disable iff (cs_n_i)
    byte_done && (rd_addr_r == FULL_MASK));

endmodule : serial_flash_read_write_engine

// *** host_link.sv ***
// host side serial master model for the flash link
`timescale 1ns/1ps
module host_link (
  // link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic so_i,
  input wire logic sio0_i,
  input wire logic so_oe_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // mode 0, clock stands low outside frames
  task automatic send(input logic [31:0] v, input int n);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = v[i];
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
  endtask : send
  task automatic recv(input bit dual, output logic [7:0] b, output logic oe);
    oe = 1'b0;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      // released line toggles so a stale level never reads back
      if (dual) mosi_o = ~mosi_o;
      #16 sclk_o = 1'b1;
      b = dual ? {b[5:0], so_i, sio0_i} : {b[6:0], so_i};
      oe = oe | so_oe_i;
      #16 sclk_o = 1'b0;
    end
  endtask : recv
  task automatic stop();
    #16 cs_n_o = 1'b1;
    #48;
  endtask : stop
endmodule : host_link

// *** testbench.sv ***
// self-checking bench for the serial flash command engine
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module testbench;
  import flash_engine_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic sclk, cs_n, mosi, sio0_w, sio0_o, sio0_oe_o, so_o, so_oe_o;
  logic wp_n = 1'b1;
  logic bp_hi = 1'b0;
  logic bp_lo = 1'b0;
  logic lock = 1'b0;
  logic busy, write_enable_latch, sleep, hw_lock, oe;
  logic [7:0] rb;
  logic [31:0] seed = 32'd95076;
  logic [7:0] mem [int];
  int num_errors = 0;
  int cmp_count = 0;
  assign sio0_w = sio0_oe_o ? sio0_o : mosi;
  host_link i_host_link (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .so_i(so_o),
    .sio0_i(sio0_w), .so_oe_i(so_oe_o));
  serial_flash_read_write_engine #(.PAGE_WRITE_CYCLES(50), .UNIT_WIPE_CYCLES(50),
    .LARGE_WIPE_CYCLES(50), .FULL_WIPE_CYCLES(50)) i_serial_flash_read_write_engine (
    .clock_i(clock_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .sio0_i(sio0_w),
    .sio0_o(sio0_o), .sio0_oe_o(sio0_oe_o), .so_o(so_o), .so_oe_o(so_oe_o),
    .write_protect_n_i(wp_n), .protect_level_high_i(bp_hi), .protect_level_low_i(bp_lo),
    .status_lock_bit_i(lock), .write_in_progress_o(busy), .write_enable_latch_o(write_enable_latch),
    .deep_sleep_o(sleep), .hardware_lock_mode_o(hw_lock));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [7:0] lfsr_byte();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : lfsr_byte
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic cycles(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cycles
  task automatic started(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(negedge clock_i);
      seen = seen | busy;
    end
    `CHK(seen, exp)
  endtask : started
  task automatic idle();
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge clock_i);
    if (busy !== 1'b0) begin
      num_errors++;
      complete_run();
    end
  endtask : idle
  task automatic op(input logic [7:0] c);
    i_host_link.send({24'h0, c}, 8);
    i_host_link.stop();
    cycles(4);
  endtask : op
  task automatic wr(input logic [7:0] c, input int a);
    i_host_link.send({c, a[23:0]}, 32);
    i_host_link.stop();
  endtask : wr
  task automatic rd(input logic [7:0] c, input int a, input int n, input logic ok);
    i_host_link.send({c, a[23:0]}, 32);
    if (c != OP_READ) i_host_link.send(32'h0, 8);
    for (int i = 0; i < n; i++) begin
      i_host_link.recv(c == OP_DUAL_READ, rb, oe);
      `CHK(oe, ok)
      if (ok) `CHK(rb, mem[(a + i) % MEM_BYTES])
    end
    if (c != OP_DUAL_READ) `CHK(sio0_oe_o, 1'b0)
    i_host_link.stop();
  endtask : rd
  task automatic stat(input logic [7:0] e);
    i_host_link.send({24'h0, OP_STATUS_READ}, 8);
    i_host_link.recv(1'b0, rb, oe);
    `CHK(rb, e)
    `CHK(sio0_oe_o, 1'b0)
    i_host_link.stop();
  endtask : stat
  task automatic pw(input int a, input int n, input logic ok);
    logic [7:0] d;
    op(OP_WRITE_UNLOCK);
    i_host_link.send({OP_PAGE_WRITE, a[23:0]}, 32);
    for (int k = 0; k < n; k++) begin
      d = lfsr_byte();
      i_host_link.send({24'h0, d}, 8);
      if (ok && k >= n - PAGE_BYTES) mem[(a & 'h1FF00) + ((a + k) & 'hFF)] &= d;
    end
    i_host_link.stop();
    started(ok);
    idle();
  endtask : pw
  task automatic wipe(input int a);
    op(OP_WRITE_UNLOCK);
    wr(OP_UNIT_WIPE, a);
    started(1'b1);
    stat(8'h03);
    rd(OP_FAST_READ, a, 1, 1'b0);
    rd(OP_DUAL_READ, a, 1, 1'b0);
    `CHK(busy, 1'b1)
    idle();
    `CHK(write_enable_latch, 1'b0)
    for (int i = 0; i < 4096; i++) mem[(a & 'h1F000) + i] = ERASED_BYTE;
  endtask : wipe
  initial begin
    cycles(4);
    reset_i = 1'b0;
    cycles(3);
    `CHK({busy, write_enable_latch, sleep, hw_lock}, 4'h0)
    wr(OP_UNIT_WIPE, 'h00ABC);
    started(1'b0);
    op(OP_WRITE_UNLOCK);
    `CHK(write_enable_latch, 1'b1)
    i_host_link.send({OP_UNIT_WIPE, 24'h0} >> 1, 31);
    i_host_link.stop();
    started(1'b0);
    i_host_link.send({23'h0, OP_FULL_WIPE, 1'b0}, 9);
    i_host_link.stop();
    started(1'b0);
    wipe('h00ABC);
    wipe('h1F123);
    pw('h00010, 258, 1'b1);
    pw('h1F0FE, 3, 1'b1);
    rd(OP_READ, 'h1FFFE, 4, 1'b1);
    rd(OP_FAST_READ, 'h1F0FC, 6, 1'b1);
    rd(OP_DUAL_READ, 'h1F000, 2, 1'b1);
    rd(OP_DUAL_READ, 'h00000, 256, 1'b1);
    cycles(1);
    bp_lo = 1'b1;
    op(OP_WRITE_UNLOCK);
    stat(8'h06);
    wr(OP_UNIT_WIPE, 'h1F000);
    started(1'b0);
    wr(OP_LARGE_WIPE, 'h10000);
    started(1'b0);
    op(OP_FULL_WIPE);
    started(1'b0);
    pw('h1F0FE, 1, 1'b0);
    `CHK(write_enable_latch, 1'b1)
    rd(OP_READ, 'h1F0FC, 6, 1'b1);
    cycles(1);
    bp_lo = 1'b0;
    op(OP_DEEP_SLEEP);
    `CHK(sleep, 1'b1)
    wr(OP_UNIT_WIPE, 'h00000);
    started(1'b0);
    rd(OP_READ, 'h00000, 1, 1'b0);
    op(OP_WAKE);
    `CHK(sleep, 1'b0)
    lock = 1'b1;
    wp_n = 1'b0;
    cycles(6);
    `CHK(hw_lock, 1'b1)
    stat(8'h82);
    wp_n = 1'b1;
    cycles(6);
    `CHK(hw_lock, 1'b0)
    complete_run();
  end
endmodule : testbench
